//--- hw/cpp_pkg.sv
// Package: constants, register map and types for the carousel pocket positioner
package cpp_pkg;
	localparam int unsigned NUM_INST      = 8;
	localparam int unsigned SENSE_W       = 4;
	localparam int unsigned POS_W         = 32;
	localparam int unsigned ENC_W         = 3;
	localparam int unsigned DIR_W         = 2;
	localparam int unsigned IDX_W         = 3;
	// Register byte addresses
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_CFG       = 8'h04;
	localparam logic [7:0]  REG_POCKET    = 8'h08;
	localparam logic [7:0]  REG_STATUS    = 8'h0c;
	localparam logic [7:0]  REG_POS       = 8'h10;
	localparam logic [7:0]  REG_STATE     = 8'h14;
	localparam logic [7:0]  REG_TICKDIV   = 8'h18;
	localparam logic [7:0]  REG_SENSE     = 8'h1c;
	localparam logic [7:0]  ADDR_MASK     = 8'hfc;
	localparam int unsigned INST_LSB      = 8;
	// Config field layout
	localparam int unsigned CFG_ENC_LSB   = 0;
	localparam int unsigned CFG_DIR_LSB   = 4;
	localparam int unsigned CFG_NS_LSB    = 8;
	localparam int unsigned CFG_PK_LSB    = 16;
	localparam int unsigned CFG_VLD_BIT   = 31;
	localparam int unsigned NS_W          = 4;
	localparam int unsigned PK_W          = 8;
	// Status bits
	localparam int unsigned ST_ACTIVE     = 0;
	localparam int unsigned ST_READY      = 1;
	localparam int unsigned ST_FWD        = 2;
	localparam int unsigned ST_REV        = 3;
	localparam int unsigned ST_HOMING     = 4;
	localparam int unsigned ST_HOMED      = 5;
	// Encodings and defaults
	localparam logic [ENC_W-1:0] ENC_GRAY   = 3'h0;
	localparam logic [ENC_W-1:0] ENC_BINARY = 3'h1;
	localparam logic [ENC_W-1:0] ENC_BCD    = 3'h2;
	localparam logic [ENC_W-1:0] ENC_INDEX  = 3'h3;
	localparam logic [ENC_W-1:0] ENC_SINGLE = 3'h4;
	localparam logic [DIR_W-1:0] DIR_UNI    = 2'h1;
	localparam logic [DIR_W-1:0] DIR_BI     = 2'h2;
	localparam logic [NS_W-1:0]  NS_DEFAULT = 4'h4;
	localparam logic [NS_W-1:0]  NS_INDEX   = 4'h2;
	localparam logic [PK_W-1:0]  PK_DEFAULT = 8'h08;
	// Evaluation tick: 1 ms at 200 MHz
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned TICK_US       = 1000;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned TDIV_W        = 24;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		CPP_IDLE,
		CPP_HOME,
		CPP_MOVE,
		CPP_DONE
	} cpp_state_e;
endpackage

//--- hw/cpp_unit.sv
// One positioner instance, evaluated on each tick
`timescale 1ns/10ps
module cpp_unit
	import cpp_pkg::*;
(
	// Clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               tick,
	// Configuration
	input  wire logic [ENC_W-1:0]   enc,
	input  wire logic [DIR_W-1:0]   dir,
	input  wire logic [NS_W-1:0]    num_sense,
	input  wire logic [PK_W-1:0]    pockets,
	// Supervisor side
	input  wire logic               enable,
	input  wire logic [POS_W-1:0]   pocket_req,
	// Synchronised sensors
	input  wire logic [SENSE_W-1:0] sense,
	// Outputs
	output logic                    active,
	output logic                    ready,
	output logic                    motor_fwd,
	output logic                    motor_rev,
	output logic                    homing,
	output logic                    homed,
	output logic [POS_W-1:0]        position,
	output logic [POS_W-1:0]        state
);
	cpp_state_e             st_q;
	logic [POS_W-1:0]       target_q;
	logic                   en_q;
	logic                   idx_prev_q;
	logic [SENSE_W-1:0]     masked;
	logic [POS_W-1:0]       decoded;
	logic [POS_W-1:0]       cur;
	logic [POS_W-1:0]       fwd_dist;
	logic [POS_W-1:0]       pk32;
	logic                   go_fwd;
	logic                   rise;

	function automatic logic [SENSE_W-1:0] gray2bin(input logic [SENSE_W-1:0] g);
		logic [SENSE_W-1:0] b;
		b[SENSE_W-1] = g[SENSE_W-1];
		for (int i = SENSE_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// Sensors above num_sense are ignored
	always_comb begin
		for (int i = 0; i < SENSE_W; i++) begin
			masked[i] = sense[i] && (i < int'(num_sense));
		end
	end

	// Position decode by feedback scheme
	always_comb begin
		decoded = '0;
		unique case (enc)
			ENC_BINARY: decoded = POS_W'(masked);
			ENC_BCD:    decoded = POS_W'(masked[3:0] > 4'h9 ? 4'h0 : masked[3:0]);
			ENC_SINGLE: begin
				for (int i = SENSE_W - 1; i >= 0; i--) begin
					if (masked[i]) begin
						decoded = POS_W'(i + 1);
					end
				end
			end
			ENC_INDEX:  decoded = position;
			default:    decoded = POS_W'(gray2bin(masked));
		endcase
	end

	assign cur      = (enc == ENC_INDEX) ? position : decoded;
	assign pk32     = POS_W'(pockets);
	assign fwd_dist = (target_q >= cur) ? target_q - cur : target_q + pk32 - cur;
	// Shorter way round; unidirectional always forward
	assign go_fwd   = (dir == DIR_UNI) || (fwd_dist <= pk32 - fwd_dist) || (fwd_dist == '0);
	assign rise     = enable && !en_q;
	assign state    = POS_W'(st_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_q <= 1'b0;
		end else if (tick) begin
			en_q <= enable;
		end
	end

	// Index mode counts pocket pulses on their rising edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			position   <= '0;
			idx_prev_q <= 1'b0;
		end else if (tick) begin
			idx_prev_q <= sense[1];
			if (enc != ENC_INDEX) begin
				position <= decoded;
			end else if (sense[0] && sense[1]) begin
				position <= POS_W'(1);
			end else if (sense[1] && !idx_prev_q && motor_fwd) begin
				position <= (position >= pk32) ? POS_W'(1) : position + POS_W'(1);
			end else if (sense[1] && !idx_prev_q && motor_rev) begin
				position <= (position <= POS_W'(1)) ? pk32 : position - POS_W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q      <= CPP_IDLE;
			target_q  <= '0;
			active    <= 1'b0;
			ready     <= 1'b0;
			motor_fwd <= 1'b0;
			motor_rev <= 1'b0;
			homing    <= 1'b0;
			homed     <= 1'b0;
		end else if (tick) begin
			unique case (st_q)
				CPP_IDLE, CPP_DONE: begin
					if (rise) begin
						active   <= 1'b1;
						ready    <= 1'b0;
						target_q <= pocket_req;
						if (enc == ENC_INDEX && !homed) begin
							// Motor starts on the next tick, after active
							homing    <= 1'b1;
							motor_rev <= 1'b0;
							st_q      <= CPP_HOME;
						end else begin
							st_q <= CPP_MOVE;
						end
					end
				end
				CPP_HOME: begin
					// Enable drop does not abort homing
					if (sense[0] && sense[1]) begin
						homing    <= 1'b0;
						homed     <= 1'b1;
						motor_fwd <= 1'b0;
						st_q      <= enable ? CPP_MOVE : CPP_IDLE;
						active    <= enable;
					end else begin
						motor_fwd <= 1'b1;
					end
				end
				CPP_MOVE: begin
					if (!enable) begin
						motor_fwd <= 1'b0;
						motor_rev <= 1'b0;
						active    <= 1'b0;
						st_q      <= CPP_IDLE;
					end else if (cur == target_q) begin
						motor_fwd <= 1'b0;
						motor_rev <= 1'b0;
						active    <= 1'b0;
						ready     <= 1'b1;
						st_q      <= CPP_DONE;
					end else begin
						motor_fwd <= go_fwd;
						motor_rev <= !go_fwd;
					end
				end
				default: st_q <= CPP_IDLE;
			endcase
		end
	end
endmodule // cpp_unit

//--- hw/cpp_top.sv
// Carousel pocket positioner: eight instances behind an AXI4-Lite slave
//
// How it works
// - Enable rising sets active in that same tick, before motion.
// - Bidirectional mode picks the shorter way and drives that direction only.
// - At target: both motors off, active low, ready high.
// - Index mode first enable rotates forward until index and pulse both high.
// - Dropping enable does not stop homing.
// - Outside homing, dropping enable releases both motor outputs.
// - Feedback scheme selectable: gray, binary, BCD, index, single; gray default.
// - Number of sense inputs per instance configurable, default four.
// - Direction option 1 unidirectional, 2 bidirectional; default bidirectional.
// - Up to eight instances, each with its own pocket count.
// - An unset instance config inherits the preceding instance's values.
// - Index mode uses two inputs: 0 index, 1 pocket pulse.
// - Single mode: each input marks one tool position.
// - Forward means higher pockets, reverse means lower pockets.
// - Decoded position always shown on a signed position output.
// - Homing and homed flags, reset to zero, index mode only.
// - Internal sequencing state readable as signed value, reset zero.
`timescale 1ns/10ps
module cpp_top
	import cpp_pkg::*;
(
	// Clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write address
	input  wire logic [11:0]                 s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [11:0]                 s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Position sensors, asynchronous
	input  wire logic [NUM_INST*SENSE_W-1:0] sense,
	// Motor driver
	output logic [NUM_INST-1:0]              motor_fwd,
	output logic [NUM_INST-1:0]              motor_rev,
	output logic [NUM_INST-1:0]              ready,
	output logic [NUM_INST-1:0]              active
);
	logic [NUM_INST*SENSE_W-1:0] s1_q;
	logic [NUM_INST*SENSE_W-1:0] s2_q;
	logic [TDIV_W-1:0]           tcnt_q;
	logic [TDIV_W-1:0]           tdiv_q;
	logic                        tick;
	logic [NUM_INST-1:0]         en_q;
	logic [31:0]                 cfg_q [NUM_INST];
	logic [POS_W-1:0]            pk_q  [NUM_INST];
	logic [ENC_W-1:0]            eff_enc [NUM_INST];
	logic [DIR_W-1:0]            eff_dir [NUM_INST];
	logic [NS_W-1:0]             eff_ns  [NUM_INST];
	logic [PK_W-1:0]             eff_pk  [NUM_INST];
	logic [NUM_INST-1:0]         homing;
	logic [NUM_INST-1:0]         homed;
	logic [POS_W-1:0]            pos   [NUM_INST];
	logic [POS_W-1:0]            state [NUM_INST];
	logic [11:0]                 awaddr_q;
	logic                        aw_have_q;
	logic [31:0]                 wdata_q;
	logic                        w_have_q;
	logic                        do_write;
	logic [IDX_W-1:0]            w_inst;
	logic [7:0]                  w_reg;
	logic [IDX_W-1:0]            r_inst;
	logic [7:0]                  r_reg;

	function automatic logic [IDX_W-1:0] inst_of(input logic [11:0] a);
		return a[INST_LSB +: IDX_W];
	endfunction

	function automatic logic [7:0] reg_of(input logic [11:0] a);
		return a[7:0] & ADDR_MASK;
	endfunction

	// Two-flop sensor synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= sense;
			s2_q <= s1_q;
		end
	end

	// Evaluation tick divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tcnt_q <= '0;
		end else if (tick) begin
			tcnt_q <= '0;
		end else begin
			tcnt_q <= tcnt_q + TDIV_W'(1);
		end
	end
	assign tick = (tcnt_q >= tdiv_q);

	// Resolve inheritance of unset instance configuration
	always_comb begin
		for (int i = 0; i < NUM_INST; i++) begin
			if (cfg_q[i][CFG_VLD_BIT] || i == 0) begin
				eff_enc[i] = cfg_q[i][CFG_ENC_LSB +: ENC_W];
				eff_dir[i] = cfg_q[i][CFG_DIR_LSB +: DIR_W];
				eff_ns[i]  = cfg_q[i][CFG_NS_LSB +: NS_W];
				eff_pk[i]  = cfg_q[i][CFG_PK_LSB +: PK_W];
			end else begin
				eff_enc[i] = eff_enc[i-1];
				eff_dir[i] = eff_dir[i-1];
				eff_ns[i]  = eff_ns[i-1];
				eff_pk[i]  = eff_pk[i-1];
			end
			if (eff_dir[i] != DIR_UNI) begin
				eff_dir[i] = DIR_BI;
			end
			if (eff_enc[i] == ENC_INDEX) begin
				eff_ns[i] = NS_INDEX;
			end
		end
	end

	// Write channel capture, address and data in either order
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready  = !w_have_q;
	assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;
	assign w_inst        = inst_of(awaddr_q);
	assign w_reg         = reg_of(awaddr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
			end else if (do_write) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (w_reg == REG_CTRL || w_reg == REG_CFG || w_reg == REG_POCKET
				|| (w_reg == REG_TICKDIV && w_inst == '0)) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Writable registers; full-word writes only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_q   <= '0;
			tdiv_q <= TDIV_W'(TICK_CYC - 1);
			for (int i = 0; i < NUM_INST; i++) begin
				cfg_q[i] <= '0;
				pk_q[i]  <= '0;
			end
			cfg_q[0] <= {1'b1, 7'h00, PK_DEFAULT, 4'h0, NS_DEFAULT, 2'h0, DIR_BI, 1'b0, ENC_GRAY};
		end else if (do_write && s_axi_wstrb == 4'hf) begin
			unique case (w_reg)
				REG_CTRL:    en_q[w_inst]  <= wdata_q[0];
				REG_CFG:     cfg_q[w_inst] <= wdata_q;
				REG_POCKET:  pk_q[w_inst]  <= wdata_q;
				REG_TICKDIV: begin
					if (w_inst == '0) begin
						tdiv_q <= wdata_q[TDIV_W-1:0];
					end
				end
				default:     ;
			endcase
		end
	end

	for (genvar g = 0; g < NUM_INST; g++) begin : g_unit
		cpp_unit u_unit (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.tick       (tick),
			.enc        (eff_enc[g]),
			.dir        (eff_dir[g]),
			.num_sense  (eff_ns[g]),
			.pockets    (eff_pk[g]),
			.enable     (en_q[g]),
			.pocket_req (pk_q[g]),
			.sense      (s2_q[g*SENSE_W +: SENSE_W]),
			.active     (active[g]),
			.ready      (ready[g]),
			.motor_fwd  (motor_fwd[g]),
			.motor_rev  (motor_rev[g]),
			.homing     (homing[g]),
			.homed      (homed[g]),
			.position   (pos[g]),
			.state      (state[g])
		);
	end

	// Read channel, one cycle latency
	assign s_axi_arready = !s_axi_rvalid;
	assign r_inst        = inst_of(s_axi_araddr);
	assign r_reg         = reg_of(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			unique case (r_reg)
				REG_CTRL:    s_axi_rdata <= {31'h0, en_q[r_inst]};
				REG_CFG:     s_axi_rdata <= {1'b0, 7'h00, eff_pk[r_inst], 4'h0, eff_ns[r_inst],
					2'h0, eff_dir[r_inst], 1'b0, eff_enc[r_inst]};
				REG_POCKET:  s_axi_rdata <= pk_q[r_inst];
				REG_STATUS:  s_axi_rdata <= {26'h0, homed[r_inst], homing[r_inst], motor_rev[r_inst],
					motor_fwd[r_inst], ready[r_inst], active[r_inst]};
				REG_POS:     s_axi_rdata <= pos[r_inst];
				REG_STATE:   s_axi_rdata <= state[r_inst];
				REG_TICKDIV: s_axi_rdata <= {8'h00, tdiv_q};
				REG_SENSE:   s_axi_rdata <= {28'h0, s2_q[r_inst*SENSE_W +: SENSE_W]};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // cpp_top

//--- tb/cpp_top_monitor.sv
// Checker of bus handshakes and motor output relations
`timescale 1ns/10ps
module cpp_top_monitor
	import cpp_pkg::*;
(
	// Clock and reset
	input wire logic                aclk,
	input wire logic                aresetn,
	// Register bus
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic [1:0]          s_axi_rresp,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	// Motor driver
	input wire logic [NUM_INST-1:0] motor_fwd,
	input wire logic [NUM_INST-1:0] motor_rev,
	input wire logic [NUM_INST-1:0] ready,
	input wire logic [NUM_INST-1:0] active
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_motor_excl: assert property (!(|(motor_fwd & motor_rev)))
		else $error("both motor outputs on");
	a_ready_still: assert property (ready[0] |-> !(motor_fwd[0] | motor_rev[0] | active[0]))
		else $error("in position while moving");
	a_active_first: assert property ($rose(active[0]) |-> !(motor_fwd[0] | motor_rev[0]))
		else $error("motion before active");
	a_ready_clear: assert property ($rose(active[0]) |-> !ready[0])
		else $error("ready kept on new move");
	a_motor_cause: assert property ($rose(motor_fwd[0] | motor_rev[0]) |-> active[0])
		else $error("motor started while idle");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while read pending");
	a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");

	c_rev_move: cover property ($rose(motor_rev[0]));
	c_fwd_move: cover property ($rose(motor_fwd[0]));
	c_arrive: cover property ($rose(ready[0]));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // cpp_top_monitor

bind cpp_top cpp_top_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .motor_fwd, .motor_rev, .ready, .active);

//--- tb/cpp_carousel_model.sv
// Carousel model: eight pockets turned by the motor outputs, sensor encoders
`timescale 1ns/10ps
module cpp_carousel_model
	import cpp_pkg::*;
#(
	parameter int STEP = 64
)
(
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// Motor commands
	input wire logic              fwd,
	input wire logic              rev,
	// Sensor scheme
	input wire logic [ENC_W-1:0]  enc,
	// Sensors and true pocket
	output logic [SENSE_W-1:0]    sense,
	output logic [3:0]            pos
);
	logic [6:0] cnt_q;
	logic       pulse;

	always_ff @(posedge aclk) begin
		if (!aresetn || !(fwd | rev) || cnt_q == 7'(STEP - 1)) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	// One pocket per step; forward counts up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos <= 4'h2;
		end else if (cnt_q == 7'(STEP - 1) && fwd) begin
			pos <= (pos == 4'h8) ? 4'h1 : pos + 4'h1;
		end else if (cnt_q == 7'(STEP - 1) && rev) begin
			pos <= (pos == 4'h1) ? 4'h8 : pos - 4'h1;
		end
	end

	// Pocket sensor lit while at rest and just after arriving
	assign pulse = !(fwd | rev) || cnt_q < 7'h08;

	always_comb begin
		case (enc)
			ENC_GRAY:   sense = pos ^ (pos >> 1);
			ENC_INDEX:  sense = {2'h0, pulse, pulse && pos == 4'h1};
			ENC_SINGLE: sense = 4'h1 << (pos - 4'h1);
			default:    sense = pos;
		endcase
	end
endmodule // cpp_carousel_model

//--- tb/testbench.sv
// Testbench of the carousel pocket positioner, instance zero
`timescale 1ns/10ps
module testbench
	import cpp_pkg::*;
;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = '0;
	logic [11:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [2:0]  enc = ENC_GRAY;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata, sense;
	wire [7:0]   motor_fwd, motor_rev, ready, active;
	wire [3:0]   s0, pos;
	wire [3:0]   st = {motor_rev[0], motor_fwd[0], ready[0], active[0]};
	logic [1:0]  seen = 2'b00;
	logic [31:0] rd_q;
	logic [1:0]  resp_q;
	int          fails = 0;
	int          tests_run = 0;

	always #2.5 aclk = ~aclk;
	assign sense = {28'h0, s0};
	always @(posedge aclk) seen <= seen | {motor_rev[0], motor_fwd[0]};

	cpp_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense, .motor_fwd, .motor_rev, .ready, .active);
	cpp_carousel_model m (.aclk, .aresetn, .fwd(motor_fwd[0]), .rev(motor_rev[0]), .enc, .sense(s0), .pos);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= {4'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		resp_q = s_axi_bresp;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [3:0] inst = 4'h0);
		s_axi_araddr <= {inst, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd_q = s_axi_rdata;
		resp_q = s_axi_rresp;
		@(posedge aclk);
	endtask

	// Wait, bounded, for one status line to reach a level
	task automatic wt(input int b, input logic v);
		int n;
		for (n = 0; n < 4000 && st[b] !== v; n++) @(posedge aclk);
		chk(32'(st[b]), 32'(v));
	endtask

	// Full move; dir is the motor output set expected, {rev, fwd}
	task automatic move(input logic [3:0] pk, input logic [1:0] dir);
		wr(REG_POCKET, 32'(pk));
		seen = 2'b00;
		wr(REG_CTRL, 32'h1);
		wt(ST_ACTIVE, 1'b1);
		chk(32'(st[ST_READY]), 32'h0);
		wt(ST_READY, 1'b1);
		chk(32'(st[3:2]), 32'h0);
		chk(32'(seen), 32'(dir));
		chk(32'(pos), 32'(pk));
		wr(REG_CTRL, 32'h0);
	endtask

	task automatic t_reset;
		rd(REG_CFG);
		chk(rd_q, 32'h0008_0420);
		rd(REG_STATE);
		chk(rd_q, 32'h0);
		rd(REG_STATUS);
		chk(rd_q, 32'h0);
		rd(8'h20);
		chk(32'(resp_q), 32'(RESP_SLVERR));
		chk(rd_q, 32'h0);
		wr(REG_TICKDIV, 32'h3);
		chk(32'(resp_q), 32'(RESP_OKAY));
		repeat (16) @(posedge aclk);
		rd(REG_POS);
		chk(rd_q, 32'h2);
	endtask

	task automatic t_bidir;
		move(4'h3, 2'b01);
		move(4'h8, 2'b10);
		move(4'h4, 2'b01);
		rd(REG_POS);
		chk(rd_q, 32'h4);
	endtask

	task automatic t_drop;
		wr(REG_POCKET, 32'h1);
		wr(REG_CTRL, 32'h1);
		wt(ST_REV, 1'b1);
		wr(REG_CTRL, 32'h0);
		wt(ST_REV, 1'b0);
		chk(32'(st[1:0]), 32'h0);
	endtask

	task automatic t_unidir;
		enc <= ENC_BINARY;
		wr(REG_CFG, 32'h8008_0411);
		rd(REG_CFG, 4'h1);
		chk(rd_q, 32'h0008_0411);
		move((pos == 4'h1) ? 4'h8 : pos - 4'h1, 2'b01);
	endtask

	task automatic t_index;
		enc <= ENC_INDEX;
		wr(REG_CFG, 32'h8008_0223);
		seen = 2'b00;
		wr(REG_CTRL, 32'h1);
		wt(ST_FWD, 1'b1);
		wr(REG_CTRL, 32'h0);
		rd(REG_STATUS);
		chk(32'(rd_q[ST_HOMING]), 32'h1);
		chk(32'(rd_q[ST_FWD]), 32'h1);
		wt(ST_FWD, 1'b0);
		rd(REG_STATUS);
		chk(32'(rd_q[ST_HOMED:ST_HOMING]), 32'h2);
		chk(32'(pos), 32'h1);
		chk(32'(seen), 32'h1);
	endtask

	task automatic t_single;
		enc <= ENC_SINGLE;
		wr(REG_CFG, 32'h8008_0404);
		move(4'h3, 2'b01);
		rd(REG_POS);
		chk(rd_q, 32'h3);
	endtask

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_bidir;
		t_drop;
		t_unidir;
		t_index;
		t_single;
		print_verdict;
	end

	// Whole run needs a few thousand cycles
	initial begin
		#200000;
		fails++;
		print_verdict;
	end
endmodule // testbench
